/* verilog/uth_framer.sv */
// Datagram framer: prefixes transfer headers to recorder packets
//
// What this block does
// R1: Header word 0 bits 3:0 carry version 0001; other codes are reserved.
// R2: Header word 0 bits 7:4 carry type: 0000 whole packets, 0001 segment.
// R3: Bits 31:8 carry a 24-bit sequence incremented for every datagram sent.
// R4: Datagrams with whole packets use only the single first header word.
// R5: Segment headers put the 16-bit channel identity in word 1 bits 15:0.
// R6: Segment headers put the 8-bit channel sequence in word 1 bits 23:16.
// R7: Word 1 bits 31:24 of a segment header are a reserved field.
// R8: Segment headers add a third word: byte offset of the segment data.
// R9: Payload is header directly followed by packet data, bytes untouched.
// R10: Packets too large for one datagram are split and sent as segments.
// R11: Datagrams with whole packets never hold a fractional packet.
// R12: Packets and segments go out in order with rising segment offset.
// R13: Each datagram message stays below 32726 bytes.
// R14: Reserved header bits are driven to zero.
// R15: The sequence counter wraps from all ones to zero silently.
`timescale 1ns/1ps
`default_nettype none
module uth_framer (
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire logic                      pkt_valid,
	output logic                           pkt_ready,
	input  wire logic [31:0]               pkt_data,
	input  wire logic                      pkt_first,
	input  wire logic [uth_pkg::LEN_W-1:0] pkt_len_words,
	input  wire logic [15:0]               pkt_chan_id,
	input  wire logic [7:0]                pkt_chan_seq,
	output logic                           dg_valid,
	input  wire logic                      dg_ready,
	output logic      [31:0]               dg_data,
	output logic                           dg_first,
	output logic                           dg_last,
	output logic                           dg_segmented
);
	localparam int LW = uth_pkg::LEN_W;
	localparam int SW = uth_pkg::SEG_CNT_W;

	// ---------------------------------------------------------------
	// Input buffering
	// ---------------------------------------------------------------
	logic [uth_pkg::FIFO_WIDTH-1:0] f_in, f_out;
	logic                           f_valid, f_pop;
	logic [31:0]                    f_data;
	logic                           f_first;
	logic [LW-1:0]                  f_len;
	logic [15:0]                    f_chan_id;
	logic [7:0]                     f_chan_seq;

	// Side fields travel with every word; only the first word's copy is used
	assign f_in = {pkt_data, pkt_first, pkt_len_words, pkt_chan_id, pkt_chan_seq};
	assign {f_data, f_first, f_len, f_chan_id, f_chan_seq} = f_out;

	uth_fifo #(
		.WIDTH (uth_pkg::FIFO_WIDTH),
		.DEPTH (uth_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_valid  (pkt_valid),
		.in_ready  (pkt_ready),
		.in_data   (f_in),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_out)
	);

	// ---------------------------------------------------------------
	// Framing state
	// ---------------------------------------------------------------
	uth_pkg::uth_state_e st_reg, st_next;
	logic                seg_reg, seg_next;
	logic [23:0]         seq_reg, seq_next;
	logic [LW-1:0]       remain_reg, remain_next;
	logic [SW-1:0]       left_reg, left_next;
	logic [31:0]         offset_reg, offset_next;
	logic [15:0]         chan_id_reg, chan_id_next;
	logic [7:0]          chan_seq_reg, chan_seq_next;
	logic                valid_reg, valid_next;
	logic [31:0]         data_reg, data_next;
	logic                first_reg, first_next;
	logic                last_reg, last_next;
	logic                can_load;
	logic [SW-1:0]       dg_words;

	// Next-state logic; at most one output word is produced per free output slot
	always_comb begin
		st_next       = st_reg;
		seg_next      = seg_reg;
		seq_next      = seq_reg;
		remain_next   = remain_reg;
		left_next     = left_reg;
		offset_next   = offset_reg;
		chan_id_next  = chan_id_reg;
		chan_seq_next = chan_seq_reg;
		data_next     = data_reg;
		first_next    = first_reg;
		last_next     = last_reg;
		f_pop         = 1'b0;
		can_load      = !valid_reg || dg_ready;
		valid_next    = valid_reg && !dg_ready;
		// Size of the next datagram's body, capped for the message limit
		dg_words = (remain_reg > LW'(uth_pkg::SEG_WORDS)) ? uth_pkg::SEG_WORDS : remain_reg[SW-1:0]; // R13
		unique case (st_reg)
			// The first word is left in the FIFO: it is also the first body word
			uth_pkg::ST_IDLE: begin
				if (f_valid && f_first && f_len != '0) begin
					remain_next   = f_len;
					chan_id_next  = f_chan_id;
					chan_seq_next = f_chan_seq;
					offset_next   = uth_pkg::OFFSET_RESET;
					seg_next      = f_len > uth_pkg::WHOLE_MAX_WORDS; // R10
					st_next       = uth_pkg::ST_HDR0;
				end else if (f_valid) begin
					// Words outside a framed packet cannot be placed; drop them
					f_pop = 1'b1;
				end
			end
			// Word 0 opens every datagram, so the sequence advances once per datagram
			// The body count is latched here, so a stall cannot change the datagram size
			uth_pkg::ST_HDR0: begin
				if (can_load) begin
					valid_next = 1'b1;
					first_next = 1'b1;
					last_next  = 1'b0;
					data_next  = '0;
					data_next[uth_pkg::VER_LSB +: 4]  = uth_pkg::VERSION_ONE; // R1
					data_next[uth_pkg::TYPE_LSB +: 4] = seg_reg ? uth_pkg::TYPE_SEGMENT
						: uth_pkg::TYPE_FULL; // R2
					data_next[uth_pkg::SEQ_LSB +: 24] = seq_reg; // R3
					seq_next   = 24'(seq_reg + 24'h000001); // R3 R15
					left_next  = seg_reg ? dg_words : remain_reg[SW-1:0]; // R11
					st_next    = seg_reg ? uth_pkg::ST_HDR1 : uth_pkg::ST_BODY; // R4
				end
			end
			// Segment word 1: reserved byte over channel sequence and identity
			uth_pkg::ST_HDR1: begin
				if (can_load) begin
					valid_next = 1'b1;
					first_next = 1'b0;
					data_next  = '0;
					data_next[uth_pkg::CHAN_ID_LSB +: 16] = chan_id_reg; // R5
					data_next[uth_pkg::CHAN_SEQ_LSB +: 8] = chan_seq_reg; // R6
					data_next[uth_pkg::RSVD_LSB +: 8]     = uth_pkg::RSVD_FILL; // R7 R14
					st_next    = uth_pkg::ST_HDR2;
				end
			end
			// Segment word 2: byte position of this segment within its packet
			uth_pkg::ST_HDR2: begin
				if (can_load) begin
					valid_next = 1'b1;
					data_next  = offset_reg; // R8
					st_next    = uth_pkg::ST_BODY;
				end
			end
			// Packet words pass through untouched; the FIFO buffers the source while headers are sent
			uth_pkg::ST_BODY: begin
				if (can_load && f_valid) begin
					f_pop       = 1'b1;
					valid_next  = 1'b1;
					first_next  = 1'b0;
					data_next   = f_data; // R9
					last_next   = left_reg == SW'(1);
					remain_next = LW'(remain_reg - LW'(1));
					left_next   = SW'(left_reg - SW'(1));
					if (left_reg == SW'(1)) begin
						if (remain_reg == LW'(1)) begin
							st_next = uth_pkg::ST_IDLE;
						end else begin
							// Next segment of the same packet follows at once
							offset_next = 32'(offset_reg + uth_pkg::SEG_BYTES); // R12
							st_next     = uth_pkg::ST_HDR0; // R10
						end
					end
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_reg       <= uth_pkg::ST_IDLE;
			seg_reg      <= 1'b0;
			seq_reg      <= uth_pkg::SEQ_RESET;
			remain_reg   <= '0;
			left_reg     <= '0;
			offset_reg   <= uth_pkg::OFFSET_RESET;
			chan_id_reg  <= '0;
			chan_seq_reg <= '0;
			valid_reg    <= 1'b0;
			data_reg     <= '0;
			first_reg    <= 1'b0;
			last_reg     <= 1'b0;
		end else begin
			st_reg       <= st_next;
			seg_reg      <= seg_next;
			seq_reg      <= seq_next;
			remain_reg   <= remain_next;
			left_reg     <= left_next;
			offset_reg   <= offset_next;
			chan_id_reg  <= chan_id_next;
			chan_seq_reg <= chan_seq_next;
			valid_reg    <= valid_next;
			data_reg     <= data_next;
			first_reg    <= first_next;
			last_reg     <= last_next;
		end
	end

	// Outputs come straight from registers
	assign dg_valid     = valid_reg;
	assign dg_data      = data_reg;
	assign dg_first     = first_reg;
	assign dg_last      = last_reg;
	assign dg_segmented = seg_reg;
endmodule
`default_nettype wire

/* verilog/uth_pkg.sv */
// Constants and types shared by the transfer-header framer and its FIFO
`default_nettype none
package uth_pkg;
	// ---------------------------------------------------------------
	// Header field layout and codes
	// ---------------------------------------------------------------
	localparam logic [3:0]  VERSION_ONE   = 4'h1;
	localparam logic [3:0]  TYPE_FULL     = 4'h0;
	localparam logic [3:0]  TYPE_SEGMENT  = 4'h1;
	localparam logic [7:0]  RSVD_FILL     = 8'h00;
	localparam logic [23:0] SEQ_RESET     = 24'h000000;
	localparam logic [31:0] OFFSET_RESET  = 32'h00000000;
	localparam int          VER_LSB       = 0;
	localparam int          TYPE_LSB      = 4;
	localparam int          SEQ_LSB       = 8;
	localparam int          CHAN_ID_LSB   = 0;
	localparam int          CHAN_SEQ_LSB  = 16;
	localparam int          RSVD_LSB      = 24;
	// ---------------------------------------------------------------
	// Datagram sizing
	// ---------------------------------------------------------------
	localparam int          MSG_LIMIT_BYTES = 32726;
	localparam int          WORD_BYTES      = 4;
	localparam int          DG_MAX_WORDS    = (MSG_LIMIT_BYTES - 1) / WORD_BYTES;
	localparam int          LEN_W           = 26;
	localparam int          SEG_CNT_W       = 14;
	localparam logic [LEN_W-1:0]     WHOLE_MAX_WORDS = LEN_W'(DG_MAX_WORDS - 1);
	localparam logic [SEG_CNT_W-1:0] SEG_WORDS       = SEG_CNT_W'(DG_MAX_WORDS - 3);
	localparam logic [31:0]          SEG_BYTES       = 32'(((DG_MAX_WORDS - 3) * WORD_BYTES));
	// ---------------------------------------------------------------
	// FIFO geometry and framer states
	// ---------------------------------------------------------------
	localparam int          FIFO_DEPTH    = 8;
	localparam int          FIFO_WIDTH    = 32 + 1 + LEN_W + 24;
	typedef enum logic [2:0] {ST_IDLE, ST_HDR0, ST_HDR1, ST_HDR2, ST_BODY} uth_state_e;
endpackage
`default_nettype wire

/* verilog/uth_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module uth_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic             rdy_reg, rdy_next;
	logic             push, pop;

	// ---------------------------------------------------------------
	// Pointers and occupancy
	// ---------------------------------------------------------------
	// Ready is registered from the next count so it never depends on the sink
	always_comb begin
		push     = in_valid && rdy_reg;
		pop      = out_valid && out_ready;
		wr_next  = push ? PW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? PW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
		rdy_next = cnt_next != FULL_CNT;
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = (push && wr_reg == PW'(i)) ? in_data : mem_reg[i];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	// Storage, one entry per generate slot
	for (genvar g = 0; g < DEPTH; g++) begin : g_mem
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				mem_reg[g] <= '0;
			end else begin
				mem_reg[g] <= mem_next[g];
			end
		end
	end

	assign in_ready  = rdy_reg;
	assign out_valid = cnt_reg != '0;
	assign out_data  = mem_reg[rd_reg];
endmodule
`default_nettype wire

/* tb/uth_framer_checker.sv */
// Concurrent checks on the framer's output stream
`timescale 1ns/1ps
`default_nettype none
module uth_framer_checker (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        pkt_valid,
	input wire logic        pkt_ready,
	input wire logic        dg_valid,
	input wire logic        dg_ready,
	input wire logic [31:0] dg_data,
	input wire logic        dg_first,
	input wire logic        dg_last,
	input wire logic        dg_segmented
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ---------------------------------------------------------------
	// Tracking of word position, sequence and offset
	// ---------------------------------------------------------------
	logic [13:0] idx_reg;
	logic        seg_reg;
	logic        have_reg;
	logic [23:0] seq_reg;
	logic [31:0] off_reg;
	// Updated only on accepted words, so stalls never move the position
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			idx_reg  <= 14'h0;
			seg_reg  <= 1'b0;
			have_reg <= 1'b0;
			seq_reg  <= 24'h0;
			off_reg  <= 32'h0;
		end else if (dg_valid && dg_ready) begin
			idx_reg <= dg_last ? 14'h0 : idx_reg + 14'h1;
			if (dg_first) begin
				seg_reg  <= dg_data[4];
				have_reg <= 1'b1;
				seq_reg  <= dg_data[31:8];
			end
			if (seg_reg && idx_reg == 14'h2)
				off_reg <= dg_data;
		end
	end
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	chk_version_one: assert property (dg_valid && dg_first |-> dg_data[3:0] == 4'h1)
		else $error("header version wrong");
	chk_type_code: assert property (dg_valid && dg_first |-> dg_data[7:5] == 3'h0)
		else $error("header type reserved");
	chk_seg_flag: assert property (dg_valid && dg_first |-> dg_data[4] == dg_segmented)
		else $error("segment flag and type disagree");
	chk_seq_start: assert property (!have_reg && dg_valid && dg_first |-> dg_data[31:8] == 24'h0)
		else $error("first sequence not zero");
	chk_seq_step: assert property (have_reg && dg_valid && dg_first |-> dg_data[31:8] == seq_reg + 24'h1)
		else $error("sequence did not step by one");
	chk_first_pos: assert property (dg_valid |-> dg_first == (idx_reg == 14'h0))
		else $error("first flag out of place");
	chk_seg_rsvd: assert property (dg_valid && seg_reg && idx_reg == 14'h1 |-> dg_data[31:24] == 8'h00)
		else $error("reserved byte not zero");
	chk_off_step: assert property (dg_valid && seg_reg && idx_reg == 14'h2 && dg_data != 32'h0
		|-> dg_data == off_reg + uth_pkg::SEG_BYTES)
		else $error("segment offset step wrong");
	chk_len_limit: assert property (dg_valid |-> idx_reg < 14'h1FF5)
		else $error("datagram too long");
	chk_hold_stall: assert property (dg_valid && !dg_ready |=> dg_valid && $stable(dg_data) && $stable(dg_last))
		else $error("output changed while stalled");
	cov_seg_hdr: cover property (dg_valid && dg_ready && seg_reg && idx_reg == 14'h2 && dg_data != 32'h0);
	cov_full: cover property (pkt_valid && !pkt_ready);
	cov_stall: cover property (dg_valid && !dg_ready);
endmodule
bind uth_framer uth_framer_checker chk (.mclk(mclk), .resetn(resetn), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
	.dg_valid(dg_valid), .dg_ready(dg_ready), .dg_data(dg_data), .dg_first(dg_first), .dg_last(dg_last),
	.dg_segmented(dg_segmented));
`default_nettype wire

/* tb/uth_sink.sv */
// Subscriber model: accepts datagram words promptly, randomly or not at all
`timescale 1ns/1ps
`default_nettype none
module uth_sink (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic [1:0] mode,
	output logic            dg_ready
);
	logic [15:0] lf_reg;
	// Mode 2 stalls indefinitely so backpressure can fill the FIFO
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lf_reg   <= 16'hACE1;
			dg_ready <= 1'b0;
		end else begin
			lf_reg   <= {lf_reg[14:0], lf_reg[15] ^ lf_reg[13] ^ lf_reg[12] ^ lf_reg[10]};
			dg_ready <= (mode == 2'h0) || (mode == 2'h1 && lf_reg[0]);
		end
	end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the transfer-header framer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        pkt_valid = 1'b0;
	logic        pkt_first = 1'b0;
	logic [31:0] pkt_data = 32'h0;
	logic [25:0] pkt_len_words = 26'h0;
	logic [15:0] pkt_chan_id = 16'h0;
	logic [7:0]  pkt_chan_seq = 8'h0;
	logic [1:0]  mode = 2'h0;
	logic [31:0] rnd = 32'h9AA1E8FB;
	logic [23:0] seq = 24'h0;
	logic [33:0] expq[$];
	logic [33:0] exp_w;
	int          bad_count = 0;
	int          n_tests = 0;
	wire logic pkt_ready, dg_valid, dg_ready, dg_first, dg_last, dg_segmented;
	wire logic [31:0] dg_data;
	always #2.5 mclk = ~mclk;
	uth_framer DUT (.mclk(mclk), .resetn(resetn), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_data(pkt_data),
		.pkt_first(pkt_first), .pkt_len_words(pkt_len_words), .pkt_chan_id(pkt_chan_id), .pkt_chan_seq(pkt_chan_seq),
		.dg_valid(dg_valid), .dg_ready(dg_ready), .dg_data(dg_data), .dg_first(dg_first), .dg_last(dg_last),
		.dg_segmented(dg_segmented));
	uth_sink SNK (.mclk(mclk), .resetn(resetn), .mode(mode), .dg_ready(dg_ready));
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check_word(input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %0t exp %h got %h", $time, e, g);
		end
	endtask
	// Single-bit levels: ready under backpressure, segment flag per datagram
	task automatic check_flag(input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %0t exp %h got %h", $time, e, g);
		end
	endtask
	// Expected header word 0, flagged as first word of a datagram
	function automatic logic [33:0] exp_hdr0(input logic [23:0] s, input logic sg);
		return {2'b10, s, 3'h0, sg, 4'h1};
	endfunction
	// Expected segment word 1: zero reserved byte, channel sequence, channel identity
	function automatic logic [33:0] exp_hdr1(input logic [23:0] c);
		return {2'b00, 8'h00, c};
	endfunction
	// Holds the word until pkt_ready is sampled high; bounded wait
	task automatic put(input logic [31:0] d, input logic f, input int len, input logic [23:0] ch);
		int k;
		pkt_valid <= 1'b1;
		pkt_data <= d;
		pkt_first <= f;
		pkt_len_words <= 26'(len);
		{pkt_chan_seq, pkt_chan_id} <= ch;
		for (k = 0; k < 3000; k++) begin
			@(posedge mclk);
			if (pkt_ready === 1'b1)
				break;
		end
		if (k == 3000) begin
			bad_count++;
			print_verdict();
		end
	endtask
	// Expectation built from the header layout while the packet is driven
	task automatic send_pkt(input int len);
		logic seg;
		logic [31:0] off;
		logic [23:0] ch;
		seg = len > 8180;
		off = 32'h0;
		rnd = lfsr(rnd);
		ch = rnd[23:0];
		for (int i = 0; i < len; i++) begin
			if (i == 0 || (seg && i % 8178 == 0)) begin
				expq.push_back(exp_hdr0(seq, seg));
				if (seg) begin
					expq.push_back(exp_hdr1(ch));
					expq.push_back({2'b00, off});
					off += 32'h7FC8;
				end
				seq++;
			end
			rnd = lfsr(rnd);
			expq.push_back({1'b0, i == len - 1 || (seg && i % 8178 == 8177), rnd});
			put(rnd, i == 0, len, ch);
			if (rnd[4:0] == 5'h0) begin
				pkt_valid <= 1'b0;
				@(posedge mclk);
			end
		end
		// One idle edge, so valid is never driven twice in one time step
		pkt_valid <= 1'b0;
		@(posedge mclk);
	endtask
	// Scoreboard on every accepted output word
	always @(posedge mclk) begin
		if (resetn && dg_valid === 1'b1 && dg_ready === 1'b1) begin
			if (expq.size() == 0)
				check_word(34'h3FFFFFFFF, {dg_first, dg_last, dg_data});
			else begin
				exp_w = expq.pop_front();
				check_word(exp_w, {dg_first, dg_last, dg_data});
				if (exp_w[33])
					check_flag(exp_w[4], dg_segmented);
			end
		end
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		mode <= 2'h1;
		send_pkt(1);
		put(32'h0, 1'b1, 0, 24'h0);
		put(32'h5, 1'b0, 3, 24'h0);
		for (int p = 0; p < 20; p++) begin
			rnd = lfsr(rnd);
			send_pkt(1 + rnd[5:0]);
		end
		mode <= 2'h2;
		fork
			send_pkt(30);
			begin
				repeat (60) @(posedge mclk);
				check_flag(1'b0, pkt_ready);
				mode <= 2'h0;
			end
		join
		send_pkt(8180);
		send_pkt(8181);
		send_pkt(16361);
		for (int k = 0; k < 2000 && expq.size() > 0; k++)
			@(posedge mclk);
		if (expq.size() > 0)
			bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
